// file: rtl/cfg_gate.sv
module cfg_gate
  import cfg_pkg::*;
(
  // Clock, reset and enable
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // Register port
  input wire logic [CFG_AW-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [CFG_DW-1:0] REG_WDATA_I,
  output logic [CFG_DW-1:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Estimates from the coarse frequency estimator
  input wire logic EST_VALID_I,
  input wire logic EST_PREDICTED_I,
  input wire logic [15:0] EST_FREQ_I,
  input wire logic [7:0] EST_CONF_I,
  // Good estimates to the frequency control loop
  output logic GOOD_VALID_O,
  output logic [15:0] GOOD_FREQ_O,
  output logic [7:0] GOOD_CONF_O,
  output logic [7:0] THRESHOLD_O
);

  cfg_state_t state_r;
  logic use_pred_r;
  logic [7:0] abs_floor_r;
  logic [7:0] rel_floor_r;
  logic [7:0] down_step_r;
  logic [9:0] bad_run_r;
  logic [7:0] abs_ceil_r;
  logic [7:0] rel_ceil_r;
  logic [7:0] up_step_r;
  logic [9:0] good_run_r;
  logic [4:0] warmup_r;
  logic [15:0] good_cnt_r;
  logic [15:0] bad_cnt_r;
  logic [7:0] th_r;
  logic [7:0] th_nxt;
  logic [15:0] raw_est_r;
  logic [7:0] raw_conf_r;
  logic [5:0] seen_r;
  logic [7:0] win_max;
  logic [7:0] lo_bound;
  logic [7:0] hi_bound;
  logic [7:0] rel_lo;
  logic [7:0] rel_hi;
  logic take;
  logic is_good;
  logic in_warmup;
  logic good_ev;
  logic bad_ev;
  logic lower_fire;
  logic raise_fire;
  logic [8:0] sum;
  logic [8:0] diff;
  logic fwd_ok;
  logic [7:0] rdata_nxt;
  logic [15:0] good_cnt_nxt;
  logic [15:0] bad_cnt_nxt;

  assign take = CE_I && EST_VALID_I && (!EST_PREDICTED_I || use_pred_r);
  assign in_warmup = state_r != CFG_ST_RUN;
  assign is_good = in_warmup || (EST_CONF_I >= th_r);
  assign good_ev = take && is_good;
  assign bad_ev = take && !is_good;

  cfg_window_max u_win (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .push_i(take),
    .data_i(EST_CONF_I),
    .max_o(win_max)
  );

  // Threshold steps follow every taken estimate; warm-up estimates count as good outcomes.
  cfg_run_counter u_bad_run (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .hit_i(bad_ev),
    .miss_i(good_ev),
    .len_i(bad_run_r),
    .fire_o(lower_fire)
  );

  cfg_run_counter u_good_run (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .hit_i(good_ev),
    .miss_i(bad_ev),
    .len_i(good_run_r),
    .fire_o(raise_fire)
  );

  // Relative bounds saturate at zero instead of wrapping round.
  always_comb
  begin
    rel_lo = (win_max > rel_floor_r) ? win_max - rel_floor_r : 8'h00;
    rel_hi = (win_max > rel_ceil_r) ? win_max - rel_ceil_r : 8'h00;
    lo_bound = (abs_floor_r > rel_lo) ? abs_floor_r : rel_lo;
    hi_bound = (abs_ceil_r < rel_hi) ? abs_ceil_r : rel_hi;
  end

  // When the bounds cross, the floor wins so the gate stays conservative.
  always_comb
  begin
    sum = {1'b0, th_r} + {1'b0, up_step_r};
    diff = {1'b0, th_r} - {1'b0, down_step_r};
    th_nxt = th_r;
    if (raise_fire)
      th_nxt = sum[8] ? 8'hff : sum[7:0];
    else if (lower_fire)
      th_nxt = diff[8] ? 8'h00 : diff[7:0];
    if (th_nxt > hi_bound)
      th_nxt = hi_bound;
    if (th_nxt < lo_bound)
      th_nxt = lo_bound;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
      th_r <= CFG_R_ABS_FLOOR;
    else if (take)
      th_r <= th_nxt;
  end

  // Warm-up counts estimates; the first forward needs warmup plus one of them.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      state_r <= CFG_ST_IDLE;
      seen_r <= '0;
    end
    else if (take)
    begin
      case (state_r)
        CFG_ST_IDLE:
        begin
          seen_r <= 6'h01;
          state_r <= (warmup_r == 5'h00) ? CFG_ST_RUN : CFG_ST_WARMUP;
        end
        CFG_ST_WARMUP:
        begin
          seen_r <= seen_r + 6'h01;
          if (seen_r >= {1'b0, warmup_r})
            state_r <= CFG_ST_RUN;
        end
        CFG_ST_RUN:
          state_r <= CFG_ST_RUN;
        default:
          state_r <= CFG_ST_IDLE;
      endcase
    end
  end

  // The estimate being taken is number seen plus one, so it may go out once that
  // reaches warmup plus one; a zero warm-up lets the very first one through.
  always_comb
  begin
    fwd_ok = 1'b0;
    case (state_r)
      CFG_ST_IDLE:
        fwd_ok = (warmup_r == 5'h00);
      CFG_ST_WARMUP:
        fwd_ok = (seen_r >= {1'b0, warmup_r});
      CFG_ST_RUN:
        fwd_ok = 1'b1;
      default:
        fwd_ok = 1'b0;
    endcase
  end

  // Forward only good estimates, and only once warm-up has gathered enough.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      GOOD_VALID_O <= 1'b0;
      GOOD_FREQ_O <= '0;
      GOOD_CONF_O <= '0;
    end
    else if (CE_I)
    begin
      GOOD_VALID_O <= good_ev && fwd_ok;
      // Warm-up estimates that are not forwarded leave the loop's data untouched.
      if (good_ev && fwd_ok)
      begin
        GOOD_FREQ_O <= EST_FREQ_I;
        GOOD_CONF_O <= EST_CONF_I;
      end
    end
  end

  // Event counters wrap at 16 bits; software reads the two bytes separately.
  always_comb
  begin
    good_cnt_nxt = good_cnt_r;
    bad_cnt_nxt = bad_cnt_r;
    if (good_ev)
      good_cnt_nxt = good_cnt_r + 16'h0001;
    if (bad_ev)
      bad_cnt_nxt = bad_cnt_r + 16'h0001;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      good_cnt_r <= '0;
      bad_cnt_r <= '0;
    end
    else if (CE_I)
    begin
      good_cnt_r <= good_cnt_nxt;
      bad_cnt_r <= bad_cnt_nxt;
    end
  end

  // Raw estimate and confidence registers follow every accepted estimate; software may overwrite only the estimate.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      raw_est_r <= '0;
      raw_conf_r <= '0;
    end
    else if (take)
    begin
      raw_est_r <= EST_FREQ_I;
      raw_conf_r <= EST_CONF_I;
    end
    else if (CE_I && REG_WR_I && REG_ADDR_I == CFG_A_EST_LO)
      raw_est_r[7:0] <= REG_WDATA_I;
    else if (CE_I && REG_WR_I && REG_ADDR_I == CFG_A_EST_HI)
      raw_est_r[15:8] <= REG_WDATA_I;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      use_pred_r <= 1'b0;
      abs_floor_r <= CFG_R_ABS_FLOOR;
      rel_floor_r <= CFG_R_REL_FLOOR;
      down_step_r <= CFG_R_DOWN_STEP;
      bad_run_r <= CFG_R_BAD_RUN;
      abs_ceil_r <= CFG_R_ABS_CEIL;
      rel_ceil_r <= CFG_R_REL_CEIL;
      up_step_r <= CFG_R_UP_STEP;
      good_run_r <= CFG_R_GOOD_RUN;
      warmup_r <= CFG_R_WARMUP;
    end
    else if (CE_I && REG_WR_I)
    begin
      case (REG_ADDR_I)
        CFG_A_CTRL: use_pred_r <= REG_WDATA_I[0];
        CFG_A_ABS_FLOOR: abs_floor_r <= REG_WDATA_I;
        CFG_A_REL_FLOOR: rel_floor_r <= REG_WDATA_I;
        CFG_A_DOWN_STEP: down_step_r <= REG_WDATA_I;
        CFG_A_BAD_RUN_LO: bad_run_r[7:0] <= REG_WDATA_I;
        CFG_A_BAD_RUN_HI: bad_run_r[9:8] <= REG_WDATA_I[1:0];
        CFG_A_ABS_CEIL: abs_ceil_r <= REG_WDATA_I;
        CFG_A_REL_CEIL: rel_ceil_r <= REG_WDATA_I;
        CFG_A_UP_STEP: up_step_r <= REG_WDATA_I;
        CFG_A_GOOD_RUN_LO: good_run_r[7:0] <= REG_WDATA_I;
        CFG_A_GOOD_RUN_HI: good_run_r[9:8] <= REG_WDATA_I[1:0];
        CFG_A_WARMUP: warmup_r <= REG_WDATA_I[4:0];
        default: use_pred_r <= use_pred_r;
      endcase
    end
  end

  // Unmapped addresses read as zero.
  always_comb
  begin
    case (REG_ADDR_I)
      CFG_A_CTRL: rdata_nxt = {7'h00, use_pred_r};
      CFG_A_GOOD_LO: rdata_nxt = good_cnt_r[7:0];
      CFG_A_GOOD_HI: rdata_nxt = good_cnt_r[15:8];
      CFG_A_BAD_LO: rdata_nxt = bad_cnt_r[7:0];
      CFG_A_BAD_HI: rdata_nxt = bad_cnt_r[15:8];
      CFG_A_ABS_FLOOR: rdata_nxt = abs_floor_r;
      CFG_A_REL_FLOOR: rdata_nxt = rel_floor_r;
      CFG_A_DOWN_STEP: rdata_nxt = down_step_r;
      CFG_A_BAD_RUN_LO: rdata_nxt = bad_run_r[7:0];
      CFG_A_BAD_RUN_HI: rdata_nxt = {6'h00, bad_run_r[9:8]};
      CFG_A_ABS_CEIL: rdata_nxt = abs_ceil_r;
      CFG_A_REL_CEIL: rdata_nxt = rel_ceil_r;
      CFG_A_UP_STEP: rdata_nxt = up_step_r;
      CFG_A_GOOD_RUN_LO: rdata_nxt = good_run_r[7:0];
      CFG_A_GOOD_RUN_HI: rdata_nxt = {6'h00, good_run_r[9:8]};
      CFG_A_WARMUP: rdata_nxt = {3'h0, warmup_r};
      CFG_A_CUR_TH: rdata_nxt = th_r;
      CFG_A_EST_LO: rdata_nxt = raw_est_r[7:0];
      CFG_A_EST_HI: rdata_nxt = raw_est_r[15:8];
      CFG_A_CONF: rdata_nxt = raw_conf_r;
      default: rdata_nxt = '0;
    endcase
  end

  // Read data is registered so that it stands steady for the whole answer cycle.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      REG_RDATA_O <= '0;
      REG_RVALID_O <= 1'b0;
      THRESHOLD_O <= CFG_R_ABS_FLOOR;
    end
    else if (CE_I)
    begin
      THRESHOLD_O <= th_r;
      REG_RVALID_O <= REG_RD_I;
      REG_RDATA_O <= rdata_nxt;
    end
  end

endmodule

// file: rtl/cfg_pkg.sv
package cfg_pkg;

  localparam int CFG_AW = 16;
  localparam int CFG_DW = 8;
  localparam int CFG_WIN_DEPTH = 8;
  localparam int CFG_WIN_IW = 3;

  // Byte-wide register map.
  localparam logic [15:0] CFG_A_CTRL = 16'h0708;
  localparam logic [15:0] CFG_A_GOOD_LO = 16'h0710;
  localparam logic [15:0] CFG_A_GOOD_HI = 16'h0711;
  localparam logic [15:0] CFG_A_BAD_LO = 16'h0715;
  localparam logic [15:0] CFG_A_BAD_HI = 16'h0716;
  localparam logic [15:0] CFG_A_ABS_FLOOR = 16'h0720;
  localparam logic [15:0] CFG_A_REL_FLOOR = 16'h0721;
  localparam logic [15:0] CFG_A_DOWN_STEP = 16'h0722;
  localparam logic [15:0] CFG_A_BAD_RUN_LO = 16'h0723;
  localparam logic [15:0] CFG_A_BAD_RUN_HI = 16'h0724;
  localparam logic [15:0] CFG_A_ABS_CEIL = 16'h0726;
  localparam logic [15:0] CFG_A_REL_CEIL = 16'h0727;
  localparam logic [15:0] CFG_A_UP_STEP = 16'h0728;
  localparam logic [15:0] CFG_A_GOOD_RUN_LO = 16'h0729;
  localparam logic [15:0] CFG_A_GOOD_RUN_HI = 16'h072a;
  localparam logic [15:0] CFG_A_WARMUP = 16'h072b;
  localparam logic [15:0] CFG_A_CUR_TH = 16'h072d;
  localparam logic [15:0] CFG_A_EST_LO = 16'h0730;
  localparam logic [15:0] CFG_A_EST_HI = 16'h0731;
  localparam logic [15:0] CFG_A_CONF = 16'h0735;

  localparam logic [7:0] CFG_R_ABS_FLOOR = 8'h90;
  localparam logic [7:0] CFG_R_REL_FLOOR = 8'h08;
  localparam logic [7:0] CFG_R_DOWN_STEP = 8'h01;
  localparam logic [9:0] CFG_R_BAD_RUN = 10'h020;
  localparam logic [7:0] CFG_R_ABS_CEIL = 8'hff;
  localparam logic [7:0] CFG_R_REL_CEIL = 8'h06;
  localparam logic [7:0] CFG_R_UP_STEP = 8'h01;
  localparam logic [9:0] CFG_R_GOOD_RUN = 10'h001;
  localparam logic [4:0] CFG_R_WARMUP = 5'h17;

  typedef enum logic [1:0] {
    CFG_ST_IDLE,
    CFG_ST_WARMUP,
    CFG_ST_RUN
  } cfg_state_t;

endpackage

// file: rtl/cfg_run_counter.sv
// Counts consecutive events and fires when the programmed length is reached.
module cfg_run_counter
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic hit_i,
  input wire logic miss_i,
  input wire logic [9:0] len_i,
  output logic fire_o
);

  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;

  // A length of zero behaves as one, so the step never locks up.
  always_comb
  begin
    cnt_nxt = cnt_r + 10'h001;
    fire_o = hit_i && (cnt_nxt >= len_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      cnt_r <= '0;
    else if (ce_i)
    begin
      if (miss_i || fire_o)
        cnt_r <= '0;
      else if (hit_i)
        cnt_r <= cnt_nxt;
    end
  end

endmodule

// file: rtl/cfg_window_max.sv
// Sliding window of the latest confidence values; reports the largest one.
module cfg_window_max
  import cfg_pkg::*;
#(
  parameter int DEPTH = CFG_WIN_DEPTH,
  parameter int IW = CFG_WIN_IW
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic push_i,
  input wire logic [7:0] data_i,
  output logic [7:0] max_o
);

  logic [7:0] win_r [DEPTH];
  logic [IW-1:0] wr_idx_r;
  logic [7:0] stage [DEPTH+1];

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      wr_idx_r <= '0;
    else if (ce_i && push_i)
      wr_idx_r <= (wr_idx_r == IW'(DEPTH - 1)) ? '0 : wr_idx_r + 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      always_ff @(posedge clk_i)
      begin
        if (!rstn_i)
          win_r[g] <= '0;
        else if (ce_i && push_i && wr_idx_r == IW'(g))
          win_r[g] <= data_i;
      end
      assign stage[g+1] = (win_r[g] > stage[g]) ? win_r[g] : stage[g];
    end
  endgenerate

  assign stage[0] = '0;
  assign max_o = stage[DEPTH];

endmodule

// file: testbench/cfg_gate_sva.sv
module cfg_gate_sva
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  // Watched ports
  input wire logic CE_I,
  input wire logic [CFG_AW-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [CFG_DW-1:0] REG_WDATA_I,
  input wire logic [CFG_DW-1:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic EST_VALID_I,
  input wire logic EST_PREDICTED_I,
  input wire logic [15:0] EST_FREQ_I,
  input wire logic [7:0] EST_CONF_I,
  input wire logic GOOD_VALID_O,
  input wire logic [15:0] GOOD_FREQ_O,
  input wire logic [7:0] GOOD_CONF_O,
  input wire logic [7:0] THRESHOLD_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RSTN_I);
  logic ctl_r;
  logic [4:0] wu_r;
  logic [5:0] nt_r;
  wire logic wr = CE_I & REG_WR_I;
  wire logic tk = CE_I & EST_VALID_I & (~EST_PREDICTED_I | ctl_r);
  always_ff @(posedge CLOCK_I)
    if (!RSTN_I)
      ctl_r <= 1'h0;
    else if (wr && REG_ADDR_I == CFG_A_CTRL)
      ctl_r <= REG_WDATA_I[0];
  always_ff @(posedge CLOCK_I)
    if (!RSTN_I)
      wu_r <= CFG_R_WARMUP;
    else if (wr && REG_ADDR_I == CFG_A_WARMUP)
      wu_r <= REG_WDATA_I[4:0];
  // The count saturates so that a long run never wraps back into warm-up.
  always_ff @(posedge CLOCK_I)
    if (!RSTN_I)
      nt_r <= 6'h00;
    else if (tk && nt_r != 6'h3f)
      nt_r <= nt_r + 6'h01;
  sequence s_warm_end;
    tk && nt_r == {1'h0, wu_r};
  endsequence
  sequence s_read_th;
    CE_I && REG_RD_I && REG_ADDR_I == CFG_A_CUR_TH;
  endsequence
  a_read_answer: assert property (CE_I && REG_RD_I |=> REG_RVALID_O)
    else $error("read answer missing");
  a_read_threshold: assert property (s_read_th |=> REG_RDATA_O == THRESHOLD_O)
    else $error("threshold read differs");
  a_forward_cause: assert property (GOOD_VALID_O |-> $past(tk))
    else $error("forward without estimate");
  a_forward_data: assert property (GOOD_VALID_O |-> GOOD_FREQ_O == $past(EST_FREQ_I)
    && GOOD_CONF_O == $past(EST_CONF_I))
    else $error("forwarded data wrong");
  a_data_holds: assert property (!GOOD_VALID_O && $past(RSTN_I) |-> $stable(GOOD_FREQ_O))
    else $error("forwarded data moved");
  a_thr_cause: assert property ($changed(THRESHOLD_O) && $past(RSTN_I) |-> $past(tk, 2))
    else $error("threshold moved alone");
  a_pred_ignored: assert property (EST_VALID_I && EST_PREDICTED_I && !ctl_r |=> !GOOD_VALID_O)
    else $error("predicted estimate used");
  a_warm_quiet: assert property (tk && nt_r < {1'h0, wu_r} |=> !GOOD_VALID_O)
    else $error("forward during warm-up");
  a_warm_first: assert property (s_warm_end |=> GOOD_VALID_O)
    else $error("first forward missing");
  a_gate_threshold: assert property (GOOD_VALID_O && nt_r > {1'h0, wu_r} + 6'h01
    |-> GOOD_CONF_O >= THRESHOLD_O)
    else $error("forward below threshold");
endmodule

bind cfg_gate cfg_gate_sva u_cfg_gate_sva (
  .CLOCK_I, .RSTN_I, .CE_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_WDATA_I,
  .REG_RDATA_O, .REG_RVALID_O, .EST_VALID_I, .EST_PREDICTED_I, .EST_FREQ_I,
  .EST_CONF_I, .GOOD_VALID_O, .GOOD_FREQ_O, .GOOD_CONF_O, .THRESHOLD_O
);

// file: testbench/cfg_gate_tb_top.sv
module cfg_gate_tb_top
  import cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic ev = 1'h0;
  logic pred = 1'h0;
  logic [15:0] addr = 16'h0;
  logic [15:0] freq = 16'h0;
  logic [7:0] wdata = 8'h0;
  logic [7:0] conf = 8'h0;
  logic [7:0] rdata, gc, th;
  logic [15:0] gf, taken, lastf;
  logic rvalid, gv;
  int miscompares = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  cfg_gate u_cfg_gate (
    .CLOCK_I(clk), .RSTN_I(rstn), .CE_I(ce), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .EST_VALID_I(ev), .EST_PREDICTED_I(pred), .EST_FREQ_I(freq), .EST_CONF_I(conf),
    .GOOD_VALID_O(gv), .GOOD_FREQ_O(gf), .GOOD_CONF_O(gc), .THRESHOLD_O(th)
  );
  cfg_loop_model u_cfg_loop_model (
    .clk_i(clk), .rstn_i(rstn), .valid_i(gv), .freq_i(gf), .taken_o(taken),
    .last_freq_o(lastf)
  );
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask
  // The answer stands for one cycle only, so it is looked at right away.
  task automatic rchk(input string w, input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    if (rvalid !== 1'h1)
    begin
      miscompares++;
      $display("mismatch read valid expected 1 seen %b", rvalid);
      test_done();
    end
    else
      chk(w, {8'h0, e}, {8'h0, rdata});
  endtask
  task automatic est(input logic [7:0] c, input logic p, input logic e);
    @(negedge clk);
    ev = 1'h1;
    pred = p;
    conf = c;
    freq = freq + 16'h0101;
    @(negedge clk);
    ev = 1'h0;
    chk("forward", {15'h0, e}, {15'h0, gv});
  endtask
  task automatic t_reset();
    logic [23:0] t[18] = '{{CFG_A_ABS_FLOOR, 8'h90}, {CFG_A_REL_FLOOR, 8'h08},
      {CFG_A_DOWN_STEP, 8'h01}, {CFG_A_BAD_RUN_LO, 8'h20}, {CFG_A_BAD_RUN_HI, 8'h00},
      {CFG_A_ABS_CEIL, 8'hff}, {CFG_A_REL_CEIL, 8'h06}, {CFG_A_UP_STEP, 8'h01},
      {CFG_A_GOOD_RUN_LO, 8'h01}, {CFG_A_GOOD_RUN_HI, 8'h00}, {CFG_A_WARMUP, 8'h17},
      {CFG_A_CTRL, 8'h00}, {CFG_A_GOOD_LO, 8'h00}, {CFG_A_GOOD_HI, 8'h00},
      {CFG_A_BAD_LO, 8'h00}, {CFG_A_BAD_HI, 8'h00}, {CFG_A_CUR_TH, 8'h90}, {16'h0700, 8'h00}};
    foreach (t[i])
      rchk("reset value", t[i][23:8], t[i][7:0]);
    wreg(CFG_A_CUR_TH, 8'h11);
    rchk("threshold", CFG_A_CUR_TH, 8'h90);
    $display("t_reset done");
  endtask
  task automatic t_warm();
    wreg(CFG_A_WARMUP, 8'h02);
    rchk("warmup", CFG_A_WARMUP, 8'h02);
    for (int i = 0; i < 3; i++)
      est(8'h10, 1'h0, i == 2);
    est(8'h10, 1'h0, 1'h0);
    rchk("threshold", CFG_A_CUR_TH, 8'h90);
    rchk("good count", CFG_A_GOOD_LO, 8'h03);
    rchk("bad count", CFG_A_BAD_LO, 8'h01);
    $display("t_warm done");
  endtask
  task automatic t_thr();
    logic [15:0] f;
    for (int i = 0; i < 5; i++)
      est(8'hc0, 1'h0, 1'h1);
    rchk("threshold", CFG_A_CUR_TH, 8'hba);
    chk("threshold pin", 16'h00ba, {8'h0, th});
    est(8'hba, 1'h0, 1'h1);
    f = freq;
    est(8'hb9, 1'h0, 1'h0);
    chk("loop freq", f, lastf);
    rchk("threshold", CFG_A_CUR_TH, 8'hba);
    $display("t_thr done");
  endtask
  task automatic t_down();
    wreg(CFG_A_BAD_RUN_LO, 8'h02);
    wreg(CFG_A_DOWN_STEP, 8'h03);
    wreg(CFG_A_REL_FLOOR, 8'hff);
    wreg(CFG_A_ABS_FLOOR, 8'h80);
    repeat (4)
      est(8'h00, 1'h0, 1'h0);
    rchk("threshold", CFG_A_CUR_TH, 8'hb4);
    est(8'hff, 1'h0, 1'h1);
    est(8'h00, 1'h0, 1'h0);
    rchk("threshold", CFG_A_CUR_TH, 8'hb5);
    $display("t_down done");
  endtask
  task automatic t_pred();
    est(8'hff, 1'h1, 1'h0);
    rchk("raw conf", CFG_A_CONF, 8'h00);
    wreg(CFG_A_CTRL, 8'h01);
    rchk("control", CFG_A_CTRL, 8'h01);
    est(8'hc7, 1'h1, 1'h1);
    chk("loop conf", 16'h00c7, {8'h0, gc});
    rchk("raw conf", CFG_A_CONF, 8'hc7);
    rchk("raw lo", CFG_A_EST_LO, freq[7:0]);
    rchk("raw hi", CFG_A_EST_HI, freq[15:8]);
    wreg(CFG_A_EST_LO, 8'h5a);
    rchk("raw write", CFG_A_EST_LO, 8'h5a);
    rchk("good count", CFG_A_GOOD_LO, 8'h0b);
    rchk("good count hi", CFG_A_GOOD_HI, 8'h00);
    rchk("bad count", CFG_A_BAD_LO, 8'h07);
    chk("loop taken", 16'h0009, taken);
    $display("t_pred done");
  endtask
  // With the enable low, neither a write nor an estimate may leave a trace.
  task automatic t_ce();
    @(negedge clk);
    ce = 1'h0;
    wreg(CFG_A_UP_STEP, 8'h44);
    est(8'hff, 1'h0, 1'h0);
    @(negedge clk);
    ce = 1'h1;
    rchk("frozen step", CFG_A_UP_STEP, 8'h01);
    rchk("frozen count", CFG_A_GOOD_LO, 8'h0b);
    $display("t_ce done");
  endtask
  // A second reset, then a zero warm-up: the first estimate goes straight out.
  task automatic t_zero();
    @(negedge clk);
    rstn = 1'h0;
    repeat (2) @(negedge clk);
    rstn = 1'h1;
    rchk("count after reset", CFG_A_GOOD_LO, 8'h00);
    wreg(CFG_A_WARMUP, 8'h00);
    est(8'h10, 1'h0, 1'h1);
    est(8'h10, 1'h0, 1'h0);
    rchk("bad count", CFG_A_BAD_LO, 8'h01);
    $display("t_zero done");
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1'h1;
    t_reset();
    t_warm();
    t_thr();
    t_down();
    t_pred();
    t_ce();
    t_zero();
    test_done();
  end
endmodule

// file: testbench/cfg_loop_model.sv
// Stands in for the frequency control loop: it takes every forwarded estimate.
module cfg_loop_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Forwarded estimates
  input wire logic valid_i,
  input wire logic [15:0] freq_i,
  output logic [15:0] taken_o,
  output logic [15:0] last_freq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i)
    if (!rstn_i)
      taken_o <= 16'h0;
    else if (valid_i)
      taken_o <= taken_o + 16'h1;
  always_ff @(posedge clk_i)
    if (valid_i)
      last_freq_o <= freq_i;
endmodule
